// ### eep_dev_end.sv
`timescale 1ns/1ps
// Operation
// - sender releases data line on ninth clock
// - ack is low on ninth clock, nack high
// - byte write: start, address, two addresses, data, stop
// - write session acks address and every byte
// - stop launches programming; no ack while busy
// - extra data bytes fill 32-byte page buffer
// - page latched, in-page address wraps, overwrites
// - stop commits all loaded bytes at once
// - master repeats request until acknowledged
// - protect input high blocks all writes
// - protect strobed before first data, nack rejects
// - array starts erased to all ones
// - read direction: ack then send current byte
// - nack then stop ends read, standby
// - address-only write loads pointer, writes nothing
// - selective read: restart with read direction
// - master ack keeps bytes coming
// - read pointer increments, wraps whole array
// - answer only type code plus strap match
// - start and stop detected while clock high
// - capture on rising, change after falling
module eep_dev_end
  import eep_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wp_i,
  input wire logic [2:0] chip_select_straps_i,
  output logic prog_busy_o,
  eep_link_if.dev link
);

  localparam int CNT_W = $clog2(PROG_CYC + 1);

  // system clock side
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_q_r;
  logic sda_q_r;
  logic start_det;
  logic stop_det;
  logic commit;
  logic frame_clr_r;
  logic dev_rst_r;
  logic busy_r;
  logic [CNT_W-1:0] prog_cnt_r;
  logic [7:0] mem_r [2**ADDR_W];

  // link clock side
  eep_dev_state_type state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] rx_byte;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] page_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_r;
  logic wr_pend_r;
  logic first_r;
  logic ack_want_r;
  logic wp_lat_r;
  logic sda_oe_n_r;
  logic sda_out_r;
  logic [1:0] busy_sync_r;
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic byte_end;
  logic data_ok;
  logic dev_match;

  ////////////////////////////////////////////////////////////////////////////
  // bus condition detection on the system clock

  // two-stage synchronisers plus one history stage per line
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], link.scl};
      sda_sync_r <= {sda_sync_r[0], link.sda};
      scl_q_r <= scl_sync_r[1];
      sda_q_r <= sda_sync_r[1];
    end
  end

  // data edges while the clock stays high
  assign start_det = scl_sync_r[1] & scl_q_r & sda_q_r & ~sda_sync_r[1];
  assign stop_det = scl_sync_r[1] & scl_q_r & ~sda_q_r & sda_sync_r[1];

  // link logic is held clear from a start or stop until the clock falls
  always_ff @(posedge clk_i) begin
    dev_rst_r <= !rstn_i;
    if (!rstn_i) begin
      frame_clr_r <= 1'b1;
    end else if (start_det || stop_det) begin
      frame_clr_r <= 1'b1;
    end else if (!scl_sync_r[1]) begin
      frame_clr_r <= 1'b0;
    end
  end

  // the link clock is idle after a stop, so its session flags are stable here
  assign commit = stop_det && wr_pend_r && !busy_r;

  // internal program cycle timer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
    end else if (commit) begin
      busy_r <= 1'b1;
      prog_cnt_r <= CNT_W'(PROG_CYC - 1);
    end else if (busy_r) begin
      if (prog_cnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        prog_cnt_r <= prog_cnt_r - 1'b1;
      end
    end
  end

  assign prog_busy_o = busy_r;

  // array: erased at reset, every loaded page byte written in one go
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
    end else if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_vld_r[i]) begin
          mem_r[{addr_r[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine on the link clock

  assign rx_byte = {shift_r[6:0], link.sda};
  assign byte_end = (bit_cnt_r == LAST_DATA_BIT);
  assign data_ok = !(first_r && wp_lat_r);
  assign dev_match = (rx_byte[7:1] == {DEV_TYPE_CODE, pin_s2_r[2:0]});

  // pin and busy synchronisers into the link domain
  always_ff @(posedge link.scl or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      busy_sync_r <= '0;
    end else begin
      pin_s1_r <= {wp_i, chip_select_straps_i};
      pin_s2_r <= pin_s1_r;
      busy_sync_r <= {busy_sync_r[0], busy_r};
    end
  end

  // bit counting, byte decode and acknowledge decision
  always_ff @(posedge link.scl or posedge frame_clr_r) begin
    if (frame_clr_r) begin
      state_r <= DS_DEVADR;
      bit_cnt_r <= '0;
      shift_r <= '0;
      ack_want_r <= 1'b0;
      first_r <= 1'b0;
      wr_pend_r <= 1'b0;
      page_vld_r <= '0;
    end else if (bit_cnt_r != ACK_SLOT) begin
      shift_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 4'h1;
      ack_want_r <= 1'b0;
      if (byte_end) begin
        unique case (state_r)
          DS_DEVADR: begin
            if (dev_match && !busy_sync_r[1]) begin
              ack_want_r <= 1'b1;
              state_r <= (rx_byte[0] == RW_READ) ? DS_RDATA : DS_ADRH;
            end else begin
              state_r <= DS_IGNORE;
            end
          end
          DS_ADRH: begin
            ack_want_r <= 1'b1;
            state_r <= DS_ADRL;
          end
          DS_ADRL: begin
            ack_want_r <= 1'b1;
            first_r <= 1'b1;
            state_r <= DS_WDATA;
          end
          DS_WDATA: begin
            first_r <= 1'b0;
            if (data_ok) begin
              ack_want_r <= 1'b1;
              wr_pend_r <= 1'b1;
              page_vld_r[addr_r[PAGE_W-1:0]] <= 1'b1;
            end else begin
              state_r <= DS_IGNORE;
            end
          end
          DS_RDATA: begin
          end
          DS_IGNORE: begin
          end
        endcase
      end
    end else begin
      bit_cnt_r <= '0;
      ack_want_r <= 1'b0;
      if (state_r == DS_RDATA && link.sda) begin
        state_r <= DS_IGNORE;
      end
    end
  end

  // page buffer storage, later bytes overwrite earlier ones
  always_ff @(posedge link.scl) begin
    if (byte_end && state_r == DS_WDATA && data_ok) begin
      page_r[addr_r[PAGE_W-1:0]] <= rx_byte;
    end
  end

  // address pointer and outgoing byte; the pointer survives between frames
  always_ff @(posedge link.scl or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      addr_r <= '0;
      tx_r <= ERASED_BYTE;
    end else if (!frame_clr_r) begin
      if (byte_end && state_r == DS_DEVADR && rx_byte[0] == RW_READ) begin
        tx_r <= mem_r[addr_r];
      end else if (byte_end && state_r == DS_ADRH) begin
        addr_r[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
      end else if (byte_end && state_r == DS_ADRL) begin
        addr_r[7:0] <= rx_byte;
      end else if (byte_end && state_r == DS_WDATA && data_ok) begin
        addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + 1'b1;
      end else if (byte_end && state_r == DS_RDATA) begin
        addr_r <= addr_r + 1'b1;
        tx_r <= mem_r[addr_r + 1'b1];
      end
    end
  end

  // data line drive, changed only after the falling clock edge
  always_ff @(negedge link.scl or posedge frame_clr_r) begin
    if (frame_clr_r) begin
      sda_oe_n_r <= 1'b1;
      sda_out_r <= 1'b0;
    end else if (bit_cnt_r == ACK_SLOT) begin
      sda_oe_n_r <= !ack_want_r;
    end else if (state_r == DS_RDATA) begin
      sda_oe_n_r <= tx_r[~bit_cnt_r[2:0]];
    end else begin
      sda_oe_n_r <= 1'b1;
    end
  end

  // protect input strobed on the falling edge before the first data bit
  always_ff @(negedge link.scl or posedge frame_clr_r) begin
    if (frame_clr_r) begin
      wp_lat_r <= 1'b0;
    end else if (state_r == DS_WDATA && first_r && bit_cnt_r == '0) begin
      wp_lat_r <= pin_s2_r[3];
    end
  end

  assign link.dev_sda_oe_n = sda_oe_n_r;
  assign link.dev_sda_o = sda_out_r;

endmodule

// ### eep_pkg.sv
package eep_pkg;

  // memory geometry
  localparam int ADDR_W = 12;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // slave address layout: fixed type code, then strap bits, then direction
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic RW_READ = 1'h1;

  // bit slots within one byte frame (eight data bits then the ninth clock)
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SCL_QTR_CYCLES = 4;

  // device end link states
  typedef enum logic [5:0] {
    DS_DEVADR = 6'h01,
    DS_ADRH = 6'h02,
    DS_ADRL = 6'h04,
    DS_WDATA = 6'h08,
    DS_RDATA = 6'h10,
    DS_IGNORE = 6'h20
  } eep_dev_state_type;

  // host end link states
  typedef enum logic [7:0] {
    HS_IDLE = 8'h01,
    HS_START = 8'h02,
    HS_DEVADR = 8'h04,
    HS_ADRH = 8'h08,
    HS_ADRL = 8'h10,
    HS_WDATA = 8'h20,
    HS_RDATA = 8'h40,
    HS_STOP = 8'h80
  } eep_host_state_type;

  // host requests
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ_CUR = 2'h1,
    OP_READ_SEL = 2'h2
  } eep_op_type;

endpackage

// ### eep_link_if.sv
`timescale 1ns/1ps
interface eep_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // open-drain data line with pull-up: low when any enabled driver pulls low
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// ### eep_host_end.sv
`timescale 1ns/1ps
module eep_host_end
  import eep_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire eep_op_type op_i,
  input wire logic [2:0] dev_sel_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [5:0] count_i,
  input wire logic [7:0] wdata_i,
  output logic wdata_take_o,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic busy_o,
  output logic done_o,
  output logic reject_o,
  eep_link_if.host link
);

  localparam int QC_W = $clog2(QTR + 1);

  eep_host_state_type state_r;
  eep_op_type op_r;
  logic [QC_W-1:0] qcnt_r;
  logic tick;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [5:0] n_r;
  logic [2:0] dev_r;
  logic [ADDR_W-1:0] addr_r;
  logic rs_r;
  logic nack_r;
  logic retry_r;
  logic scl_r;
  logic oe_n_r;
  logic [1:0] sda_s_r;
  logic take_r;
  logic rvalid_r;
  logic [7:0] rdata_r;
  logic done_r;
  logic reject_r;
  logic busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // quarter-period timebase and data line synchroniser

  always_ff @(posedge clk_i) begin
    if (!rstn_i || qcnt_r == QC_W'(QTR - 1)) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + 1'b1;
    end
  end

  assign tick = (qcnt_r == QC_W'(QTR - 1));

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sda_s_r <= 2'h3;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer: each slot is four quarters, clock low-high-high-low, except the stop slot, which ends with the clock high

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r <= HS_IDLE;
      op_r <= OP_WRITE;
      q_r <= '0;
      bit_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      n_r <= '0;
      dev_r <= '0;
      addr_r <= '0;
      rs_r <= 1'b0;
      nack_r <= 1'b0;
      retry_r <= 1'b0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      take_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      done_r <= 1'b0;
      reject_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      take_r <= 1'b0;
      rvalid_r <= 1'b0;
      done_r <= 1'b0;
      if (state_r == HS_IDLE) begin
        scl_r <= 1'b1;
        oe_n_r <= 1'b1;
        q_r <= '0;
        if (req_i) begin
          op_r <= op_i;
          dev_r <= dev_sel_i;
          addr_r <= addr_i;
          n_r <= count_i;
          rs_r <= 1'b0;
          reject_r <= 1'b0;
          busy_r <= 1'b1;
          state_r <= HS_START;
        end
      end else if (tick) begin
        q_r <= q_r + 2'h1;
        unique case (q_r)
          2'h0: begin
            scl_r <= 1'b0;
            if (state_r == HS_START) begin
              oe_n_r <= 1'b1;
            end else if (state_r == HS_STOP) begin
              oe_n_r <= 1'b0;
            end else if (bit_r == ACK_SLOT) begin
              // last read byte gets a nack, earlier ones an ack
              oe_n_r <= (state_r == HS_RDATA) ? (n_r == 6'h1) : 1'b1;
            end else begin
              oe_n_r <= (state_r == HS_RDATA) ? 1'b1 : tx_r[~bit_r[2:0]];
            end
          end
          2'h1: begin
            scl_r <= 1'b1;
          end
          2'h2: begin
            if (state_r == HS_START) begin
              oe_n_r <= 1'b0;
            end else if (state_r == HS_STOP) begin
              oe_n_r <= 1'b1;
            end else if (bit_r == ACK_SLOT) begin
              nack_r <= sda_s_r[1];
            end else begin
              rx_r <= {rx_r[6:0], sda_s_r[1]};
            end
          end
          2'h3: begin
            scl_r <= (state_r == HS_STOP);
            if (state_r == HS_START) begin
              tx_r <= {DEV_TYPE_CODE, dev_r, (op_r == OP_READ_CUR) || rs_r};
              bit_r <= '0;
              state_r <= HS_DEVADR;
            end else if (state_r == HS_STOP) begin
              retry_r <= 1'b0;
              rs_r <= 1'b0;
              done_r <= !retry_r;
              busy_r <= retry_r;
              state_r <= retry_r ? HS_START : HS_IDLE;
            end else if (bit_r != ACK_SLOT) begin
              bit_r <= bit_r + 4'h1;
            end else begin
              bit_r <= '0;
              if (state_r != HS_RDATA && nack_r) begin
                // refused address restarts the request, refused byte ends it
                retry_r <= (state_r == HS_DEVADR);
                reject_r <= (state_r != HS_DEVADR);
                state_r <= HS_STOP;
              end else begin
                unique case (state_r)
                  HS_DEVADR: begin
                    tx_r <= {4'h0, addr_r[ADDR_W-1:8]};
                    state_r <= tx_r[0] ? HS_RDATA : HS_ADRH;
                  end
                  HS_ADRH: begin
                    tx_r <= addr_r[7:0];
                    state_r <= HS_ADRL;
                  end
                  HS_ADRL: begin
                    if (op_r == OP_READ_SEL) begin
                      rs_r <= 1'b1;
                      state_r <= HS_START;
                    end else begin
                      tx_r <= wdata_i;
                      take_r <= 1'b1;
                      state_r <= HS_WDATA;
                    end
                  end
                  HS_WDATA: begin
                    n_r <= n_r - 6'h1;
                    if (n_r == 6'h1) begin
                      state_r <= HS_STOP;
                    end else begin
                      tx_r <= wdata_i;
                      take_r <= 1'b1;
                    end
                  end
                  HS_RDATA: begin
                    rdata_r <= rx_r;
                    rvalid_r <= 1'b1;
                    n_r <= n_r - 6'h1;
                    if (n_r == 6'h1) begin
                      state_r <= HS_STOP;
                    end
                  end
                  default: begin
                    state_r <= HS_STOP;
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  assign link.scl = scl_r;
  assign link.host_sda_oe_n = oe_n_r;
  assign link.host_sda_o = 1'b0;
  assign wdata_take_o = take_r;
  assign rdata_o = rdata_r;
  assign rdata_valid_o = rvalid_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign reject_o = reject_r;

endmodule

// ### eep_link_props.sv
`timescale 1ns/1ps
module eep_link_props
  import eep_pkg::*;
#(
  parameter int PROG_CYC = 200
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic prog_busy_o,
  input wire logic [2:0] chip_select_straps_i
);
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic busy_frame_r;
  logic [3:0] since_stop_r;
  int busy_len_r;
  logic rise_w;
  logic start_w;
  logic stop_w;
  logic addr_ok_w;

  ////////////////////////////////////////////////////////////////////////////
  // line events seen from the system clock
  assign rise_w = scl & ~scl_q_r;
  assign start_w = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_w = scl & scl_q_r & ~sda_q_r & sda;
  assign addr_ok_w = (shift_r[7:4] == DEV_TYPE_CODE) && (shift_r[3:1] == chip_select_straps_i);

  // previous line levels
  always_ff @(posedge clk_i) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
  end

  // clock rises since start, held at all ones after a stop or after the fifteenth rise of a frame
  always_ff @(posedge clk_i) begin
    if (!rstn_i || stop_w) begin
      bit_cnt_r <= 4'hf;
    end else if (start_w) begin
      bit_cnt_r <= 4'h0;
    end else if (rise_w && bit_cnt_r != 4'hf) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // bits captured on clock rises, msb first
  always_ff @(posedge clk_i) begin
    if (rise_w) begin
      shift_r <= {shift_r[6:0], sda};
    end
  end

  // busy seen anywhere in the current frame
  always_ff @(posedge clk_i) begin
    if (start_w) begin
      busy_frame_r <= prog_busy_o;
    end else if (prog_busy_o) begin
      busy_frame_r <= 1'b1;
    end
  end

  // cycles since the last stop, saturating
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      since_stop_r <= 4'hf;
    end else if (stop_w) begin
      since_stop_r <= 4'h0;
    end else if (since_stop_r != 4'hf) begin
      since_stop_r <= since_stop_r + 4'h1;
    end
  end

  // length of the current program cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !prog_busy_o) begin
      busy_len_r <= 0;
    end else begin
      busy_len_r <= busy_len_r + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence ack_slot_s;
    rise_w && (bit_cnt_r == 4'h8);
  endsequence

  sequence start_s;
    start_w;
  endsequence

  dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data moved while clock high");
  one_sender_a: assert property (scl |-> (dev_sda_oe_n || host_sda_oe_n))
    else $error("both ends pull the data line");
  addr_ack_a: assert property (ack_slot_s ##0 (addr_ok_w && !busy_frame_r) |-> !sda)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (ack_slot_s ##0 !addr_ok_w |-> sda)
    else $error("foreign address acknowledged");
  prog_after_stop_a: assert property ($rose(prog_busy_o) |-> since_stop_r <= 4'h8)
    else $error("program cycle without stop");
  prog_length_a: assert property ($fell(prog_busy_o) |-> busy_len_r == PROG_CYC)
    else $error("program cycle length wrong");
  busy_quiet_a: assert property (prog_busy_o |-> dev_sda_oe_n)
    else $error("device drives line while programming");
  start_hold_a: assert property (start_s |-> ##1 scl [*2])
    else $error("clock dropped right after start");
endmodule

// ### serial_eeprom_bus_slave_tb_top.sv
`timescale 1ns/1ps
module serial_eeprom_bus_slave_tb_top;
  import eep_pkg::*;
  localparam int PROG_N = 200;
  localparam int LIMIT = 20000;
  logic clk_i;
  logic rstn_i;
  logic req_i;
  eep_op_type op_i;
  logic [2:0] dev_sel_i;
  logic [ADDR_W-1:0] addr_i;
  logic [5:0] count_i;
  logic [7:0] wdata_i;
  logic wdata_take_o;
  logic [7:0] rdata_o;
  logic rdata_valid_o;
  logic busy_o;
  logic done_o;
  logic reject_o;
  logic prog_busy_o;
  logic wp_i;
  logic [2:0] straps;
  int n_fail;
  int total_checks;
  int mem[4096];
  int ptr;
  int dn;
  logic [31:0] lfsr;
  logic [7:0] wq[$];

  ////////////////////////////////////////////////////////////////////////////
  // both ends joined on one link, checker beside it
  eep_link_if link_if();
  eep_host_end eep_host_end_i (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .op_i(op_i),
    .dev_sel_i(dev_sel_i), .addr_i(addr_i), .count_i(count_i), .wdata_i(wdata_i),
    .wdata_take_o(wdata_take_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .busy_o(busy_o), .done_o(done_o), .reject_o(reject_o), .link(link_if.host));
  eep_dev_end #(.PROG_CYC(PROG_N)) eep_dev_end_i (.clk_i(clk_i), .rstn_i(rstn_i), .wp_i(wp_i),
    .chip_select_straps_i(straps), .prog_busy_o(prog_busy_o), .link(link_if.dev));
  eep_link_props #(.PROG_CYC(PROG_N)) eep_link_props_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .scl(link_if.scl), .sda(link_if.sda), .host_sda_oe_n(link_if.host_sda_oe_n),
    .dev_sda_oe_n(link_if.dev_sda_oe_n), .prog_busy_o(prog_busy_o),
    .chip_select_straps_i(straps));

  // system clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // model array back to erased state
  task automatic model_reset();
    foreach (mem[i]) mem[i] = int'(ERASED_BYTE);
    ptr = 0;
  endtask

  // random write bytes into the queue
  task automatic fill(input int cnt);
    wq.delete();
    repeat (cnt) begin
      lfsr = lfsr_next(lfsr);
      wq.push_back(lfsr[7:0]);
    end
  endtask

  // one host request, served and checked against the model
  task automatic do_op(input eep_op_type op, input int addr, input int cnt, input logic rej);
    int n;
    int k;
    int nr;
    int tkc;
    logic tk;
    n = 0;
    k = 1;
    nr = 0;
    tkc = 0;
    if (op == OP_READ_SEL) ptr = addr;
    @(posedge clk_i);
    #1;
    op_i = op;
    dev_sel_i = straps;
    addr_i = 12'(addr);
    count_i = 6'(cnt);
    wdata_i = wq[0];
    req_i = 1'b1;
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    check(32'(busy_o), 32'h0000_0001);
    while (done_o !== 1'b1 && n < LIMIT) begin
      tk = (wdata_take_o === 1'b1);
      if (rdata_valid_o === 1'b1) begin
        check(32'(rdata_o), 32'(mem[ptr]));
        ptr = (ptr + 1) % 4096;
        nr++;
      end
      @(posedge clk_i);
      #1;
      n++;
      if (tk) tkc++;
      if (tk && k < cnt) begin
        wdata_i = wq[k];
        k++;
      end
    end
    if (n >= LIMIT) begin
      n_fail++;
      tally_and_finish();
    end
    check(32'(reject_o), 32'(rej));
    if (op != OP_WRITE) check(32'(nr), 32'(cnt));
    if (op == OP_WRITE && !rej) begin
      check(32'(tkc), 32'(cnt));
      for (int i = 0; i < cnt; i++) begin
        mem[(addr & 32'h0000_0fe0) | ((addr + i) & 31)] = int'(wq[i]);
      end
      ptr = (addr & 32'h0000_0fe0) | ((addr + cnt) & 31);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_fail = 0;
    total_checks = 0;
    rstn_i = 1'b0;
    req_i = 1'b0;
    op_i = OP_WRITE;
    dev_sel_i = 3'h0;
    addr_i = 12'h000;
    count_i = 6'h01;
    wdata_i = 8'h00;
    wp_i = 1'b0;
    straps = 3'h0;
    lfsr = 32'h0000_63b3;
    model_reset();
    fill(1);
    repeat (4) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    // erased array, two bytes from location zero
    do_op(OP_READ_CUR, 0, 2, 1'b0);
    // page load past the page end overwrites its own first bytes
    straps = lfsr[2:0];
    fill(34);
    do_op(OP_WRITE, 32'h0000_003c, 34, 1'b0);
    do_op(OP_READ_SEL, 32'h0000_0020, 32, 1'b0);
    // protected write refused, array unchanged
    fill(2);
    wp_i = 1'b1;
    do_op(OP_WRITE, 32'h0000_0020, 2, 1'b1);
    wp_i = 1'b0;
    do_op(OP_READ_SEL, 32'h0000_0020, 2, 1'b0);
    // read past the top of the array wraps to zero
    straps = lfsr[5:3];
    fill(2);
    do_op(OP_WRITE, 32'h0000_0ffe, 2, 1'b0);
    do_op(OP_READ_SEL, 32'h0000_0ffe, 4, 1'b0);
    do_op(OP_READ_CUR, 0, 1, 1'b0);
    // frames to another strap value are never answered
    dn = 0;
    op_i = OP_READ_CUR;
    dev_sel_i = straps ^ 3'h1;
    count_i = 6'h01;
    req_i = 1'b1;
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    repeat (3000) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) dn++;
    end
    check(32'(dn), 32'h0000_0000);
    // reset in mid-run refills the array
    rstn_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    model_reset();
    do_op(OP_READ_CUR, 0, 1, 1'b0);
    tally_and_finish();
  end
endmodule
